// >>> hdl/isw_top.sv
// interrupt controller with stop mode and pin wake-up
//
// The Wishbone register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module isw_top (
  input wire logic clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [isw_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [isw_pkg::DAT_W-1:0] wb_dat_i,
  output logic [isw_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // event sources, same clock
  input wire logic wdog_evt,
  input wire logic [isw_pkg::NTMR-1:0] tmr_evt,
  input wire logic [isw_pkg::NSPI-1:0] spi_evt,
  input wire logic [isw_pkg::NMISC-1:0] misc_evt,
  // external pins and crystal status, asynchronous
  input wire logic [isw_pkg::NPIN-1:0] ext_pin,
  input wire logic xtal_ready,
  // processor core
  input wire logic core_take,
  input wire logic core_return,
  output logic irq_req,
  output logic [isw_pkg::REG_W-1:0] irq_vector,
  // clock and power control
  output logic xtal_halt,
  output logic rc_halt,
  output logic core_halt,
  output logic run_on_rc
);
  import isw_pkg::*;

  typedef struct packed {
    // sticky flags and enables per group
    logic [NGRP-1:0][REG_W-1:0] flag;
    logic [NGRP-1:0][REG_W-1:0] en;
    // pin edge select, 0 rising, 1 falling
    logic [NPIN-1:0] edge_sel;
    // software registers
    logic [REG_W-1:0] vector;
    logic [REG_W-1:0] mod_mask;
    logic gen;
    logic xwait;
    // service and stop/wake state
    logic in_svc;
    isw_wake_t wst;
    // bus response
    logic ack;
    logic [DAT_W-1:0] dat;
    // registered outputs
    logic irq;
    logic xtal_halt;
    logic rc_halt;
    logic core_halt;
    logic run_rc;
  } isw_top_t;

  isw_top_t r;
  isw_top_t n;

  // ====================
  // pin conditioner
  isw_pin_if pif ();

  isw_pin_cond u_pins (
    .clk(clk),
    .rstn(rstn),
    .ext_pin(ext_pin),
    .xtal_ready(xtal_ready),
    .pif(pif)
  );

  assign pif.edge_sel = r.edge_sel;

  // ====================
  // helpers
  // byte-lane merge of a 16-bit register
  function automatic logic [REG_W-1:0] merge16(
    input logic [REG_W-1:0] old,
    input logic [DAT_W-1:0] d,
    input logic [3:0] sel
  );
    logic [REG_W-1:0] res;
    res = old;
    if (sel[0]) begin
      res[7:0] = d[7:0];
    end
    if (sel[1]) begin
      res[15:8] = d[15:8];
    end
    return res;
  endfunction

  // word index of a group's flag or enable register
  function automatic logic [IDX_W-1:0] grp_idx(input int g, input logic is_en);
    return IDX_FLAG_BASE + IDX_W'(2 * g) + {{(IDX_W-1){1'b0}}, is_en};
  endfunction

  // byte-lane merge of an 8-bit edge-select half
  function automatic logic [7:0] merge8(
    input logic [7:0] old,
    input logic [DAT_W-1:0] d,
    input logic [3:0] sel
  );
    logic [7:0] res;
    res = old;
    if (sel[0]) begin
      res = d[7:0];
    end
    return res;
  endfunction

  // group has an enabled flag and its module enabled
  function automatic logic grp_pend(
    input logic [REG_W-1:0] flags,
    input logic [REG_W-1:0] ens,
    input logic mod_en
  );
    return (|(flags & ens)) && mod_en;
  endfunction

  // ====================
  // next state
  // per-cycle source events and decode
  logic [NGRP-1:0][REG_W-1:0] evt;
  logic [NGRP-1:0] pend;
  logic [REG_W-1:0] clr;
  logic [REG_W-1:0] srcid;
  logic [REG_W-1:0] ctrl_rd;
  logic [REG_W-1:0] rd;
  logic hit;
  logic wr;
  logic mapped;
  logic wake;
  logic [IDX_W-1:0] idx;

  always_comb begin
    n = r;
    // bus decode
    idx = wb_adr_i[ADR_W-1:2];
    hit = wb_cyc_i && wb_stb_i && !r.ack;
    wr = hit && wb_we_i;
    clr = '0;
    rd = '0;
    mapped = 1'b0;

    evt = '0;
    evt[GRP_SYS][0] = wdog_evt;
    evt[GRP_P0][7:0] = pif.pin_evt[7:0];
    evt[GRP_P1][7:0] = pif.pin_evt[15:8];
    evt[GRP_TMR][NTMR-1:0] = tmr_evt;
    evt[GRP_SPI][NSPI-1:0] = spi_evt;
    evt[GRP_MISC][NMISC-1:0] = misc_evt;

    // flag set/clear and enable writes per group
    for (int g = 0; g < NGRP; g++) begin
      clr = (wr && idx == grp_idx(g, 1'b0)) ? merge16('0, wb_dat_i, wb_sel_i) : '0;
      // set ignores enables, set beats clear
      n.flag[g] = ((r.flag[g] & ~clr) | evt[g]) & GRP_MASK[g];
      if (wr && idx == grp_idx(g, 1'b1)) begin
        n.en[g] = merge16(r.en[g], wb_dat_i, wb_sel_i) & GRP_MASK[g];
      end
    end

    // ====================
    // register writes
    if (wr) begin
      unique case (idx)
        IDX_VECTOR: n.vector = merge16(r.vector, wb_dat_i, wb_sel_i);
        IDX_MODMASK: n.mod_mask = merge16(r.mod_mask, wb_dat_i, wb_sel_i);
        IDX_EDGE_P0: n.edge_sel[7:0] = merge8(r.edge_sel[7:0], wb_dat_i, wb_sel_i);
        IDX_EDGE_P1: n.edge_sel[15:8] = merge8(r.edge_sel[15:8], wb_dat_i, wb_sel_i);
        IDX_CTRL: begin
          if (wb_sel_i[0]) begin
            n.gen = wb_dat_i[CTRL_GEN];
            n.xwait = wb_dat_i[CTRL_XWAIT];
          end
        end
        default: begin
        end
      endcase
    end

    // ====================
    // stop and wake
    // wake on an enabled pin edge
    wake = |({r.en[GRP_P1][7:0], r.en[GRP_P0][7:0]} & pif.pin_evt);
    unique case (r.wst)
      WK_RUN: begin
        if (wr && idx == IDX_CTRL && wb_sel_i[0] && wb_dat_i[CTRL_STOP]) begin
          n.wst = WK_STOPPED;
          // a fresh stop drops the rc-run mark
          n.run_rc = 1'b0;
        end
      end
      WK_STOPPED: begin
        // only an enabled pin edge wakes
        if (wake) begin
          if (r.xwait && !pif.xtal_rdy) begin
            n.wst = WK_WARMUP;
          end else begin
            n.wst = WK_RUN;
            n.run_rc = !pif.xtal_rdy;
          end
        end
      end
      WK_WARMUP: begin
        if (pif.xtal_rdy) begin
          n.wst = WK_RUN;
        end
      end
      default: n.wst = WK_RUN;
    endcase
    if (pif.xtal_rdy) begin
      n.run_rc = 1'b0;
    end
    n.xtal_halt = (n.wst == WK_STOPPED);
    n.rc_halt = (n.wst == WK_STOPPED);
    n.core_halt = (n.wst != WK_RUN);

    // ====================
    // service state
    if (core_return) begin
      n.in_svc = 1'b0;
    end
    if (core_take) begin
      n.in_svc = 1'b1;
    end

    // ====================
    // request gating
    // gating from next flags
    for (int g = 0; g < NGRP; g++) begin
      pend[g] = grp_pend(n.flag[g], r.en[g], r.mod_mask[g]);
    end
    n.irq = r.gen && !n.in_svc && (|pend);

    // ====================
    // identification
    // system or peripheral origin
    srcid = '0;
    for (int g = 0; g < NGRP; g++) begin
      srcid[SRC_GRP + g] = grp_pend(r.flag[g], r.en[g], r.mod_mask[g]);
    end
    srcid[SRC_SYS] = srcid[SRC_GRP + GRP_SYS];
    srcid[SRC_PERIPH] = |srcid[SRC_GRP + NGRP - 1:SRC_GRP + 1];

    // control and status word
    ctrl_rd = '0;
    ctrl_rd[CTRL_GEN] = r.gen;
    ctrl_rd[CTRL_STOP] = (r.wst == WK_STOPPED);
    ctrl_rd[CTRL_XWAIT] = r.xwait;
    ctrl_rd[CTRL_INSVC] = r.in_svc;
    ctrl_rd[CTRL_RUNRC] = r.run_rc;

    // ====================
    // read mux
    for (int g = 0; g < NGRP; g++) begin
      if (idx == grp_idx(g, 1'b0)) begin
        rd = r.flag[g];
        mapped = 1'b1;
      end
      if (idx == grp_idx(g, 1'b1)) begin
        rd = r.en[g];
        mapped = 1'b1;
      end
    end
    if (!mapped) begin
      unique case (idx)
        IDX_VECTOR: rd = r.vector;
        IDX_MODMASK: rd = r.mod_mask;
        IDX_SRCID: rd = srcid;
        IDX_CTRL: rd = ctrl_rd;
        IDX_EDGE_P0: rd = {8'h00, r.edge_sel[7:0]};
        IDX_EDGE_P1: rd = {8'h00, r.edge_sel[15:8]};
        default: rd = '0;
      endcase
    end

    // unmapped words acknowledge and read zero
    n.ack = hit;
    n.dat = (hit && !wb_we_i) ? {16'h0000, rd} : '0;
  end

  // ====================
  // registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r.flag <= '0;
      r.en <= {NGRP{ENABLE_RST}};
      r.edge_sel <= EDGE_RST;
      r.vector <= VECTOR_RST;
      r.mod_mask <= MODMASK_RST;
      r.gen <= 1'b0;
      r.xwait <= 1'b0;
      r.in_svc <= 1'b0;
      r.wst <= WK_RUN;
      r.ack <= 1'b0;
      r.dat <= '0;
      r.irq <= 1'b0;
      r.xtal_halt <= 1'b0;
      r.rc_halt <= 1'b0;
      r.core_halt <= 1'b0;
      r.run_rc <= 1'b0;
    end else begin
      r <= n;
    end
  end

  // ====================
  // outputs, all from flip-flops
  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign irq_req = r.irq;
  assign irq_vector = r.vector;
  assign xtal_halt = r.xtal_halt;
  assign rc_halt = r.rc_halt;
  assign core_halt = r.core_halt;
  assign run_on_rc = r.run_rc;

endmodule

// >>> shared/isw_pkg.sv
// constants and types of the interrupt and stop/wake unit
package isw_pkg;

  // ==================== bus geometry ====================
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int REG_W = 16;
  localparam int IDX_W = 6;

  // ==================== source groups ====================
  localparam int NGRP = 6;
  localparam int GRP_SYS = 0;
  localparam int GRP_P0 = 1;
  localparam int GRP_P1 = 2;
  localparam int GRP_TMR = 3;
  localparam int GRP_SPI = 4;
  localparam int GRP_MISC = 5;
  localparam int NPIN = 16;
  localparam int NTMR = 11;
  localparam int NSPI = 4;
  localparam int NMISC = 11;
  // implemented flag bits of each group, index 0 on the right
  localparam logic [NGRP-1:0][REG_W-1:0] GRP_MASK = {16'h07ff, 16'h000f, 16'h07ff, 16'h00ff, 16'h00ff, 16'h0001};

  // ==================== register word indices (byte address = 4 x index) ====================
  localparam logic [IDX_W-1:0] IDX_VECTOR = 6'h00;
  localparam logic [IDX_W-1:0] IDX_MODMASK = 6'h01;
  localparam logic [IDX_W-1:0] IDX_SRCID = 6'h02;
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h03;
  localparam logic [IDX_W-1:0] IDX_FLAG_BASE = 6'h04;
  localparam logic [IDX_W-1:0] IDX_EDGE_P0 = 6'h10;
  localparam logic [IDX_W-1:0] IDX_EDGE_P1 = 6'h11;

  // ==================== field positions ====================
  localparam int CTRL_GEN = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_XWAIT = 2;
  localparam int CTRL_INSVC = 3;
  localparam int CTRL_RUNRC = 4;
  localparam int SRC_SYS = 0;
  localparam int SRC_PERIPH = 1;
  localparam int SRC_GRP = 8;

  // ==================== reset values ====================
  localparam logic [REG_W-1:0] VECTOR_RST = 16'h0000;
  localparam logic [REG_W-1:0] MODMASK_RST = 16'h0000;
  localparam logic [REG_W-1:0] ENABLE_RST = 16'h0000;
  localparam logic [REG_W-1:0] EDGE_RST = 16'h0000;

  // ==================== stop/wake states ====================
  typedef enum logic [1:0] {
    WK_RUN = 2'b00,
    WK_STOPPED = 2'b01,
    WK_WARMUP = 2'b10
  } isw_wake_t;

endpackage

// >>> shared/isw_pin_if.sv
// carrier between the pin conditioner and the interrupt unit
`timescale 1ns/1ps
interface isw_pin_if;
  import isw_pkg::*;
  logic [NPIN-1:0] edge_sel;
  logic [NPIN-1:0] pin_evt;
  logic xtal_rdy;
  modport ctl (output edge_sel, input pin_evt, input xtal_rdy);
  modport pins (input edge_sel, output pin_evt, output xtal_rdy);
endinterface

// >>> hdl/isw_pin_cond.sv
// synchronisers and edge detectors for external interrupt pins
`timescale 1ns/1ps
module isw_pin_cond (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [isw_pkg::NPIN-1:0] ext_pin,
  input wire logic xtal_ready,
  isw_pin_if.pins pif
);
  import isw_pkg::*;

  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] prev;
    logic [1:0] warm;
    logic x1;
    logic x2;
  } isw_cond_t;

  isw_cond_t r;
  isw_cond_t n;

  always_comb begin
    n = r;
    n.s1 = ext_pin;
    n.s2 = r.s1;
    n.prev = r.s2;
    if (!(&r.warm)) begin
      n.warm = r.warm + 2'h1;
    end
    n.x1 = xtal_ready;
    n.x2 = r.x1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // selected edge detect
  // edge select 0 picks rising, 1 picks falling
  // no edges until prev holds a synced sample, else a high pin fakes one after reset
  assign pif.pin_evt = {NPIN{&r.warm}} & ((~pif.edge_sel & r.s2 & ~r.prev) | (pif.edge_sel & ~r.s2 & r.prev));
  assign pif.xtal_rdy = r.x2;

endmodule

// >>> verif/isw_props.sv
// assertion checker for the interrupt and stop/wake unit
`timescale 1ns/1ps
module isw_props
  import isw_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [isw_pkg::DAT_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [isw_pkg::NPIN-1:0] ext_pin,
  input wire logic core_take,
  input wire logic core_return,
  input wire logic irq_req,
  input wire logic [isw_pkg::REG_W-1:0] irq_vector,
  input wire logic xtal_halt,
  input wire logic rc_halt,
  input wire logic core_halt,
  input wire logic run_on_rc
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ====================
  // bus and registers
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data outside ack");
  a_vector_reset: assert property (!$past(rstn) |-> irq_vector == 16'h0000)
    else $error("vector not zero after reset");
  a_vector_write: assert property (!$stable(irq_vector) |-> wb_ack_o && $past(wb_we_i))
    else $error("vector changed without write");
  // ====================
  // service and stop
  a_take_drops: assert property (core_take |-> ##[1:2] !irq_req)
    else $error("request held after take");
  a_service_blocks: assert property (core_take ##1 (!core_return) [*3] |-> !irq_req)
    else $error("request during service");
  a_halt_together: assert property (xtal_halt |-> rc_halt && core_halt)
    else $error("partial halt");
  a_rc_running: assert property (run_on_rc |-> !core_halt && !xtal_halt)
    else $error("rc run while halted");
  a_stop_holds: assert property ((xtal_halt && $stable(ext_pin)) [*6] |=> xtal_halt)
    else $error("stop left without pin");
endmodule
bind isw_top isw_props u_isw_props (.clk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o,
  .ext_pin, .core_take, .core_return, .irq_req, .irq_vector, .xtal_halt, .rc_halt, .core_halt, .run_on_rc);

// >>> verif/isw_core_mdl.sv
// processor core model: accepts requests and returns from service
`timescale 1ns/1ps
module isw_core_mdl (
  input wire logic clk,
  input wire logic rstn,
  input wire logic irq_req,
  input wire logic serve,
  input wire logic fin,
  output logic core_take,
  output logic core_return
);
  logic in_svc_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_take <= 1'b0;
      core_return <= 1'b0;
      in_svc_r <= 1'b0;
    end else begin
      core_take <= serve && irq_req && !in_svc_r && !core_take;
      if (core_take)
        in_svc_r <= 1'b1;
      core_return <= fin && in_svc_r && !core_return;
      if (core_return)
        in_svc_r <= 1'b0;
    end
  end
endmodule

// >>> verif/isw_top_tb.sv
// self-checking bench of the interrupt and stop/wake unit
`timescale 1ns/1ps
module isw_top_tb;
  import isw_pkg::*;
  logic clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0, wdog = 0, xrdy = 0, serve = 0, fin = 0;
  logic [7:0] adr = '0;
  logic [31:0] wdat = '0, rdat, q;
  logic [10:0] tmr = '0, misc = '0;
  logic [3:0] spi = '0;
  logic [15:0] pin = '0, vec;
  logic ack, take, ret, irq, xh, rh, ch, rc;
  int n_errors = 0, check_count = 0, cycles = 0;
  always #12.5 clk = ~clk;
  isw_top u_isw_top (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .wdog_evt(wdog), .tmr_evt(tmr),
    .spi_evt(spi), .misc_evt(misc), .ext_pin(pin), .xtal_ready(xrdy), .core_take(take), .core_return(ret),
    .irq_req(irq), .irq_vector(vec), .xtal_halt(xh), .rc_halt(rh), .core_halt(ch), .run_on_rc(rc));
  isw_core_mdl u_isw_core_mdl (.clk(clk), .rstn(rstn), .irq_req(irq), .serve(serve), .fin(fin),
    .core_take(take), .core_return(ret));
  task automatic print_verdict();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic [5:0] i, input logic w, input logic [15:0] d);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {16'h0000, d};
    @(posedge clk);
    while (ack !== 1'b1) begin
      @(posedge clk);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [5:0] i, input logic [15:0] d);
    bus(i, 1'b1, d);
  endtask
  task automatic rd(input logic [5:0] i, input logic [15:0] e);
    bus(i, 1'b0, 16'h0000);
    chk(q, {16'h0000, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    tick(2);
    rstn <= 1'b1;
    tick(1);
    rd(IDX_VECTOR, 16'h0000);
    rd(IDX_MODMASK, 16'h0000);
    wr(IDX_VECTOR, 16'h1234);
    rd(IDX_VECTOR, 16'h1234);
    chk(vec, 32'h0000_1234);
    wdog <= 1'b1;
    tmr <= '1;
    spi <= '1;
    misc <= '1;
    tick(1);
    {wdog, tmr, spi, misc} <= '0;
    tick(1);
    rd(6'h04, GRP_MASK[GRP_SYS]);
    rd(6'h0A, GRP_MASK[GRP_TMR]);
    rd(6'h0C, GRP_MASK[GRP_SPI]);
    rd(6'h0E, GRP_MASK[GRP_MISC]);
    wr(6'h0B, 16'h0001);
    wr(6'h05, 16'h0001);
    wr(IDX_MODMASK, 16'h0009);
    rd(IDX_SRCID, 16'h0903);
    chk(irq, 0);
    wr(IDX_CTRL, 16'h0001);
    chk(irq, 1);
    wr(6'h04, 16'h0001);
    chk(irq, 1);
    wr(6'h0A, 16'h07ff);
    chk(irq, 0);
    rd(6'h0A, 16'h0000);
    tmr <= 11'h001;
    serve <= 1'b1;
    tick(1);
    tmr <= '0;
    tick(4);
    chk(irq, 0);
    wr(6'h0A, 16'h0001);
    fin <= 1'b1;
    tick(1);
    fin <= 1'b0;
    serve <= 1'b0;
    wr(6'h07, 16'h0001);
    wr(IDX_EDGE_P1, 16'h0001);
    rd(IDX_EDGE_P1, 16'h0001);
    pin <= 16'h0101;
    tick(5);
    rd(6'h06, 16'h0001);
    chk(irq, 0);
    rd(6'h08, 16'h0000);
    pin <= 16'h0000;
    tick(5);
    rd(6'h08, 16'h0001);
    wr(6'h06, 16'h0001);
    wr(IDX_CTRL, 16'h0003);
    tick(8);
    chk({xh, rh, ch}, 3'b111);
    pin <= 16'h0001;
    tick(8);
    chk({ch, rc}, 2'b01);
    xrdy <= 1'b1;
    tick(5);
    chk(rc, 0);
    pin <= 16'h0000;
    xrdy <= 1'b0;
    tick(5);
    wr(6'h06, 16'h0001);
    wr(IDX_CTRL, 16'h0007);
    tick(8);
    pin <= 16'h0001;
    tick(8);
    chk({xh, ch}, 2'b01);
    xrdy <= 1'b1;
    tick(6);
    chk(ch, 0);
    wr(IDX_CTRL, 16'h0003);
    tick(2);
    chk(xh, 1);
    rstn <= 1'b0;
    tick(2);
    rstn <= 1'b1;
    tick(1);
    chk({xh, rh, ch, rc}, 4'h0);
    rd(IDX_VECTOR, 16'h0000);
    rd(6'h06, 16'h0000);
    print_verdict();
  end
endmodule
